// ---- rtl/ircg_pkg.sv ----
`default_nettype none
package ircg_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] MODE_IDX = 8'he8;
    localparam logic [7:0] CNT_HIGH_IDX = 8'hba;
    localparam logic [7:0] CARRIER_HIGH_IDX = 8'hbb;
    localparam logic [7:0] CARRIER_LOW_IDX = 8'hbc;
    localparam logic [7:0] CNT_LOW_IDX = 8'hbd;
    localparam logic [7:0] OUT_DATA_IDX = 8'hbe;
    localparam logic [7:0] OUT_BUF_IDX = 8'hbf;
    localparam logic [7:0] LEN_BUF_HIGH_IDX = 8'hc2;
    localparam logic [7:0] LEN_BUF_LOW_IDX = 8'hc3;
    localparam logic [7:0] LEN_HIGH_IDX = 8'hc4;
    localparam logic [7:0] LEN_LOW_IDX = 8'hc5;

    localparam int ADDR_W = 12;

    // mode register field positions
    localparam int MODE_FLAG_BIT = 7;
    localparam int MODE_CARRIER_EN_BIT = 6;
    localparam int MODE_CARRIER_SEL_LSB = 4;
    localparam int MODE_PULSE_EN_BIT = 3;
    localparam int MODE_PULSE_SEL_LSB = 0;

    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CARRIER_COUNT_RST = 8'hff;
    localparam logic [15:0] PULSE_LEN_RST = 16'hffff;
    localparam logic [15:0] PULSE_CNT_RST = 16'h0000;
    localparam logic DATA_BIT_RST = 1'b0;

    // divider widths and the pulse select code that means carrier edges
    localparam int DIV_W = 6;
    localparam logic [2:0] PULSE_SEL_CARRIER = 3'h7;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'b00, idx, 2'b00};
    endfunction

    // terminal count of the carrier divider: divide by 1, 2, 3 or 4
    function automatic logic [DIV_W-1:0] carrier_limit(input logic [1:0] sel);
        carrier_limit = {4'h0, sel};
    endfunction

    // terminal count of the pulse divider: divide by 1,2,3,4,8,16,64
    function automatic logic [DIV_W-1:0] pulse_limit(input logic [2:0] sel);
        case (sel)
            3'h0: pulse_limit = 6'h00;
            3'h1: pulse_limit = 6'h01;
            3'h2: pulse_limit = 6'h02;
            3'h3: pulse_limit = 6'h03;
            3'h4: pulse_limit = 6'h07;
            3'h5: pulse_limit = 6'h0f;
            3'h6: pulse_limit = 6'h3f;
            default: pulse_limit = 6'h00;
        endcase
    endfunction

endpackage
`default_nettype wire

// ---- rtl/ircg_tick_div.sv ----
`default_nettype none
// one-cycle enable pulse every limit+1 clocks while run is high
module ircg_tick_div #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [W-1:0] limit,
    // tick out
    output logic tick
);
    logic [W-1:0] cnt_ff;

    assign tick = run && (cnt_ff >= limit);

    // held at zero while stopped so the first period after start is whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (!run || tick) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ircg_carrier.sv ----
`default_nettype none
// carrier phase generator: high for high_count ticks, low for low_count ticks
module ircg_carrier (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic tick,
    input wire logic [7:0] high_count,
    input wire logic [7:0] low_count,
    // carrier level
    output logic carrier_signal
);
    logic [7:0] cnt_ff;
    logic high_phase_ff;
    logic [7:0] target;
    logic [8:0] cnt_inc;

    assign target = high_phase_ff ? high_count : low_count;
    assign cnt_inc = {1'b0, cnt_ff} + 9'h001;
    assign carrier_signal = run && high_phase_ff;

    // a zero count ends its phase at the first tick; counts are not latched,
    // so a rewrite mid-phase applies to the phase in progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
            high_phase_ff <= 1'b1;
        end else if (!run) begin
            cnt_ff <= 8'h00;
            high_phase_ff <= 1'b1;
        end else if (tick) begin
            if (cnt_inc >= {1'b0, target}) begin
                cnt_ff <= 8'h00;
                high_phase_ff <= !high_phase_ff;
            end else begin
                cnt_ff <= cnt_inc[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ircg_top.sv ----
`default_nettype none
// Operation
// - pin output built from carrier and data bit, each controlled on its own.
// - carrier enable bit turns carrier generation on and off.
// - on a pulse match the data bit takes the output buffer value.
// - software write to the data register updates it at once.
// - four output mixes: carrier on/off, data from buffer or software.
// - carrier high phase lasts high count times carrier tick period.
// - carrier low phase lasts low count times carrier tick period.
// - data pulse high phase lasts pulse length times pulse tick period.
// - data pulse low phase lasts the pulse length then in effect.
// - carrier disabled: pin shows only the data bit.
// - counter reaching pulse length sets match flag and requests interrupt.
// - pulse counter and match requests only while pulse enable is one.
// - match flag is readable in the mode register.
// - flag clears on service, pulse enable clear, or written zero.
// - low byte of pulse counter is read-only, resets to zero.
// - data and buffer registers hold one bit, reset to zero.
// - carrier enabled: pin is carrier AND data; disabled: carrier counter stops.
// - at each match pulse length reloads from its buffer.
// - carrier tick select picks clock divided by 1 to 4, while enabled.
// - pulse tick select picks divide 1..64 or carrier edges, while enabled.
module ircg_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ircg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt handshake with the interrupt controller
    input wire logic irq_service,
    output logic pulse_irq_req,
    // remote output pin
    output logic remote_output_pin
);
    // mode register fields
    logic pulse_match_flag_ff;
    logic carrier_enable_ff;
    logic [1:0] carrier_clk_sel_ff;
    logic pulse_enable_ff;
    logic [2:0] pulse_clk_sel_ff;
    // timing registers
    logic [7:0] carrier_high_count_ff;
    logic [7:0] carrier_low_count_ff;
    logic [15:0] pulse_length_ff;
    logic [15:0] pulse_length_buffer_ff;
    logic [15:0] pulse_counter_ff;
    // data bit and its buffer
    logic remote_data_bit_ff;
    logic remote_output_buffer_ff;
    // bus answer registers, pin register and carrier edge history
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic remote_output_pin_ff;
    logic carrier_prev_ff;
    // internal nets
    logic carrier_tick;
    logic div_tick;
    logic pulse_tick;
    logic carrier_signal;
    logic pulse_match;
    logic [16:0] pulse_inc;
    logic setup_phase;
    logic wr_commit;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [7:0] mode_value;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pulse_irq_req = pulse_match_flag_ff;
    assign remote_output_pin = remote_output_pin_ff;

    // only byte lane 0 carries data; a write with lane 0 off changes nothing
    assign setup_phase = psel && !penable;
    assign wr_commit = psel && penable && pready_ff && pwrite && !pslverr_ff && pstrb[0];
    assign wr_byte = pwdata[7:0];

    assign mode_value = {pulse_match_flag_ff, carrier_enable_ff, carrier_clk_sel_ff,
                         pulse_enable_ff, pulse_clk_sel_ff};

    // carrier tick divider runs only while the carrier is enabled
    ircg_tick_div #(
        .W(ircg_pkg::DIV_W)
    ) u_carrier_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(carrier_enable_ff),
        .limit(ircg_pkg::carrier_limit(carrier_clk_sel_ff)),
        .tick(carrier_tick)
    );

    ircg_carrier u_carrier (
        .pclk(pclk),
        .presetn(presetn),
        .run(carrier_enable_ff),
        .tick(carrier_tick),
        .high_count(carrier_high_count_ff),
        .low_count(carrier_low_count_ff),
        .carrier_signal(carrier_signal)
    );

    // pulse tick divider runs only while pulse enable is set
    ircg_tick_div #(
        .W(ircg_pkg::DIV_W)
    ) u_pulse_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(pulse_enable_ff && (pulse_clk_sel_ff != ircg_pkg::PULSE_SEL_CARRIER)),
        .limit(ircg_pkg::pulse_limit(pulse_clk_sel_ff)),
        .tick(div_tick)
    );

    // top select code counts rising carrier edges instead of divided clock
    assign pulse_tick = pulse_enable_ff &&
        ((pulse_clk_sel_ff == ircg_pkg::PULSE_SEL_CARRIER) ?
         (carrier_signal && !carrier_prev_ff) : div_tick);

    // zero length is taken as a match on every tick
    assign pulse_inc = {1'b0, pulse_counter_ff} + 17'h00001;
    assign pulse_match = pulse_tick &&
        ((pulse_inc == {1'b0, pulse_length_ff}) || (pulse_length_ff == 16'h0000));

    // carrier edge history for the carrier-clocked pulse counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_prev_ff <= 1'b0;
        end else begin
            carrier_prev_ff <= carrier_signal;
        end
    end

    // data pulse counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_counter_ff <= ircg_pkg::PULSE_CNT_RST;
        end else if (!pulse_enable_ff) begin
            pulse_counter_ff <= ircg_pkg::PULSE_CNT_RST;
        end else if (pulse_match) begin
            pulse_counter_ff <= ircg_pkg::PULSE_CNT_RST;
        end else if (pulse_tick) begin
            pulse_counter_ff <= pulse_inc[15:0];
        end
    end

    // match flag: hardware set wins over every clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_match_flag_ff <= ircg_pkg::MODE_RST[ircg_pkg::MODE_FLAG_BIT];
        end else if (pulse_match) begin
            pulse_match_flag_ff <= 1'b1;
        end else if (wr_commit && paddr == ircg_pkg::reg_addr(ircg_pkg::MODE_IDX)) begin
            // written zero clears, written one sets, pulse enable off clears
            pulse_match_flag_ff <= wr_byte[ircg_pkg::MODE_FLAG_BIT] &&
                                   wr_byte[ircg_pkg::MODE_PULSE_EN_BIT];
        end else if (irq_service || !pulse_enable_ff) begin
            pulse_match_flag_ff <= 1'b0;
        end
    end

    // mode control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_enable_ff <= ircg_pkg::MODE_RST[ircg_pkg::MODE_CARRIER_EN_BIT];
            carrier_clk_sel_ff <= ircg_pkg::MODE_RST[ircg_pkg::MODE_CARRIER_SEL_LSB +: 2];
            pulse_enable_ff <= ircg_pkg::MODE_RST[ircg_pkg::MODE_PULSE_EN_BIT];
            pulse_clk_sel_ff <= ircg_pkg::MODE_RST[ircg_pkg::MODE_PULSE_SEL_LSB +: 3];
        end else if (wr_commit && paddr == ircg_pkg::reg_addr(ircg_pkg::MODE_IDX)) begin
            carrier_enable_ff <= wr_byte[ircg_pkg::MODE_CARRIER_EN_BIT];
            carrier_clk_sel_ff <= wr_byte[ircg_pkg::MODE_CARRIER_SEL_LSB +: 2];
            pulse_enable_ff <= wr_byte[ircg_pkg::MODE_PULSE_EN_BIT];
            pulse_clk_sel_ff <= wr_byte[ircg_pkg::MODE_PULSE_SEL_LSB +: 3];
        end
    end

    // carrier phase counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_high_count_ff <= ircg_pkg::CARRIER_COUNT_RST;
            carrier_low_count_ff <= ircg_pkg::CARRIER_COUNT_RST;
        end else if (wr_commit) begin
            if (paddr == ircg_pkg::reg_addr(ircg_pkg::CARRIER_HIGH_IDX)) begin
                carrier_high_count_ff <= wr_byte;
            end
            if (paddr == ircg_pkg::reg_addr(ircg_pkg::CARRIER_LOW_IDX)) begin
                carrier_low_count_ff <= wr_byte;
            end
        end
    end

    // pulse length buffer, software only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_length_buffer_ff <= ircg_pkg::PULSE_LEN_RST;
        end else if (wr_commit) begin
            if (paddr == ircg_pkg::reg_addr(ircg_pkg::LEN_BUF_HIGH_IDX)) begin
                pulse_length_buffer_ff[15:8] <= wr_byte;
            end
            if (paddr == ircg_pkg::reg_addr(ircg_pkg::LEN_BUF_LOW_IDX)) begin
                pulse_length_buffer_ff[7:0] <= wr_byte;
            end
        end
    end

    // pulse length: reload at match beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_length_ff <= ircg_pkg::PULSE_LEN_RST;
        end else if (pulse_match) begin
            pulse_length_ff <= pulse_length_buffer_ff;
        end else if (wr_commit) begin
            if (paddr == ircg_pkg::reg_addr(ircg_pkg::LEN_HIGH_IDX)) begin
                pulse_length_ff[15:8] <= wr_byte;
            end
            if (paddr == ircg_pkg::reg_addr(ircg_pkg::LEN_LOW_IDX)) begin
                pulse_length_ff[7:0] <= wr_byte;
            end
        end
    end

    // output buffer bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_output_buffer_ff <= ircg_pkg::DATA_BIT_RST;
        end else if (wr_commit && paddr == ircg_pkg::reg_addr(ircg_pkg::OUT_BUF_IDX)) begin
            remote_output_buffer_ff <= wr_byte[0];
        end
    end

    // data bit: match reload from buffer, else direct software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_data_bit_ff <= ircg_pkg::DATA_BIT_RST;
        end else if (pulse_match) begin
            remote_data_bit_ff <= remote_output_buffer_ff;
        end else if (wr_commit && paddr == ircg_pkg::reg_addr(ircg_pkg::OUT_DATA_IDX)) begin
            remote_data_bit_ff <= wr_byte[0];
        end
    end

    // pin mix, registered so the pin never glitches on decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_output_pin_ff <= 1'b0;
        end else if (carrier_enable_ff) begin
            remote_output_pin_ff <= carrier_signal && remote_data_bit_ff;
        end else begin
            remote_output_pin_ff <= remote_data_bit_ff;
        end
    end

    // read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            ircg_pkg::reg_addr(ircg_pkg::MODE_IDX): rd_byte = mode_value;
            ircg_pkg::reg_addr(ircg_pkg::CNT_HIGH_IDX): rd_byte = pulse_counter_ff[15:8];
            ircg_pkg::reg_addr(ircg_pkg::CARRIER_HIGH_IDX): rd_byte = carrier_high_count_ff;
            ircg_pkg::reg_addr(ircg_pkg::CARRIER_LOW_IDX): rd_byte = carrier_low_count_ff;
            ircg_pkg::reg_addr(ircg_pkg::CNT_LOW_IDX): rd_byte = pulse_counter_ff[7:0];
            ircg_pkg::reg_addr(ircg_pkg::OUT_DATA_IDX): rd_byte = {7'h00, remote_data_bit_ff};
            ircg_pkg::reg_addr(ircg_pkg::OUT_BUF_IDX): rd_byte = {7'h00, remote_output_buffer_ff};
            ircg_pkg::reg_addr(ircg_pkg::LEN_BUF_HIGH_IDX): rd_byte = pulse_length_buffer_ff[15:8];
            ircg_pkg::reg_addr(ircg_pkg::LEN_BUF_LOW_IDX): rd_byte = pulse_length_buffer_ff[7:0];
            ircg_pkg::reg_addr(ircg_pkg::LEN_HIGH_IDX): rd_byte = pulse_length_ff[15:8];
            ircg_pkg::reg_addr(ircg_pkg::LEN_LOW_IDX): rd_byte = pulse_length_ff[7:0];
            default: rd_hit = 1'b0;
        endcase
    end

    // apb answer: no wait states, data sampled at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pready_ff <= 1'b1;
            pslverr_ff <= !rd_hit;
        end else begin
            // reads counter one cycle before completion; fine for slow counts
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- test/ircg_props.sv ----
`default_nettype none
module ircg_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ircg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt and pin
    input wire logic irq_service,
    input wire logic pulse_irq_req,
    input wire logic remote_output_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr, wr_mode, wr_data;
    logic cen_ff, pe_ff, data_ff, known_ff;
    assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign wr_mode = wr && paddr == {2'b00, ircg_pkg::MODE_IDX, 2'b00};
    assign wr_data = wr && paddr == {2'b00, ircg_pkg::OUT_DATA_IDX, 2'b00};
    // shadow of the two enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cen_ff <= 1'b0;
            pe_ff <= 1'b0;
        end else if (wr_mode) begin
            cen_ff <= pwdata[ircg_pkg::MODE_CARRIER_EN_BIT];
            pe_ff <= pwdata[ircg_pkg::MODE_PULSE_EN_BIT];
        end
    end
    // data bit is only predictable while no match can reload it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= 1'b0;
            known_ff <= 1'b1;
        end else begin
            data_ff <= wr_data ? pwdata[0] : data_ff;
            known_ff <= pe_ff ? 1'b0 : (known_ff || wr_data);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    // a match on the edge that turns pulse enable off still sets the flag for one cycle
    a_irq_needs_enable: assert property (pulse_irq_req |-> pe_ff || $fell(pe_ff))
        else $error("match request while pulse counter disabled");
    a_flag_clear_disable: assert property ($fell(pe_ff) |=> !pulse_irq_req)
        else $error("flag survived pulse disable");
    a_flag_write_set: assert property (wr_mode && pwdata[7] && pwdata[3]
        |=> pulse_irq_req)
        else $error("written flag not set");
    a_pin_plain_data: assert property ($past(known_ff && !cen_ff) |->
        remote_output_pin == $past(data_ff))
        else $error("pin differs from data bit with carrier off");
    a_pin_data_low: assert property ($past(known_ff && !data_ff)
        |-> !remote_output_pin)
        else $error("pin high while data bit low");
    a_carrier_starts_high: assert property ($rose(cen_ff) && known_ff
        && data_ff |=> remote_output_pin)
        else $error("carrier did not start high");
endmodule
bind ircg_top ircg_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_service(irq_service),
    .pulse_irq_req(pulse_irq_req), .remote_output_pin(remote_output_pin));
`default_nettype wire

// ---- test/ircg_led_model.sv ----
`default_nettype none
// led driver on the pin: counts flashes, has nothing to drive back
module ircg_led_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin from the block
    input wire logic remote_output_pin,
    // flash count
    output logic [15:0] flashes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_ff;
    // a flash starts on each rising pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'b0;
            flashes <= 16'h0;
        end else begin
            pin_ff <= remote_output_pin;
            flashes <= flashes + {15'h0, remote_output_pin && !pin_ff};
        end
    end
endmodule
`default_nettype wire

// ---- test/ir_carrier_generator_tb_top.sv ----
`default_nettype none
module ir_carrier_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic irq_service = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pulse_irq_req, remote_output_pin;
    logic [15:0] flashes;
    logic [7:0] h, l, m;
    logic [32:0] exp_q[$];
    int fails = 0, total_checks = 0, cycles = 0, n, hi, lo;
    int divs[8] = '{1, 2, 3, 4, 8, 16, 64, 2};
    always #12.5 pclk = ~pclk;
    ircg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_service(irq_service),
        .pulse_irq_req(pulse_irq_req), .remote_output_pin(remote_output_pin));
    ircg_led_model led (.pclk(pclk), .presetn(presetn), .remote_output_pin(remote_output_pin),
        .flashes(flashes));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: measured %0d expected %0d", $time, got, exp);
        end
    endtask
    // one apb transfer, request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic err);
        exp_q.push_back({err, 24'h0, d});
        apb(1'b0, idx, 8'h00);
    endtask
    task automatic run_len(input logic lvl, output int k);
        k = 0;
        while (remote_output_pin === lvl) begin
            @(posedge pclk);
            k++;
        end
    endtask
    // wait for the flag, then service it; clearing costs two edges
    task automatic run_flag(output int k);
        k = 2;
        while (pulse_irq_req !== 1'b1) begin
            @(posedge pclk);
            k++;
        end
        irq_service <= 1'b1;
        @(posedge pclk);
        irq_service <= 1'b0;
        @(posedge pclk);
    endtask
    // read results are compared in order of issue
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cmp_rd({pslverr, prdata}, exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h7af958e0));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values across the map; c0 and c1 are holes
        for (int i = 8'hba; i <= 8'hc5; i++) begin
            rd(i[7:0], (i inside {8'hbb, 8'hbc, [8'hc2:8'hc5]}) ? 8'hff : 8'h00,
                i inside {8'hc0, 8'hc1});
        end
        rd(ircg_pkg::MODE_IDX, 8'h00, 1'b0);
        $display("test reset done");
        // read-write bytes, read-only counter, one-bit data registers
        for (int i = 8'hbb; i <= 8'hc5; i++) begin
            m = 8'($urandom);
            apb(1'b1, i[7:0], m);
            // keep the buffer bit; m is overwritten by later passes
            if (i == 8'hbf) begin
                l = m;
            end
            if (i inside {8'hbb, 8'hbc, [8'hc2:8'hc5]}) begin
                rd(i[7:0], m, 1'b0);
            end
        end
        rd(ircg_pkg::CNT_LOW_IDX, 8'h00, 1'b0);
        rd(ircg_pkg::OUT_BUF_IDX, {7'h0, l[0]}, 1'b0);
        apb(1'b1, ircg_pkg::MODE_IDX, 8'h35);
        rd(ircg_pkg::MODE_IDX, 8'h35, 1'b0);
        apb(1'b1, ircg_pkg::OUT_DATA_IDX, 8'hff);
        // byte lane 0 off: this write must leave the data bit alone
        pstrb <= 4'he;
        apb(1'b1, ircg_pkg::OUT_DATA_IDX, 8'h00);
        pstrb <= 4'hf;
        rd(ircg_pkg::OUT_DATA_IDX, 8'h01, 1'b0);
        cmp_val({31'h0, remote_output_pin}, 32'h1);
        $display("test registers done");
        // carrier phases for each tick divider, data bit held high
        for (int c = 0; c < 4; c++) begin
            h = 8'(1 + $urandom % 6);
            l = 8'(1 + $urandom % 6);
            apb(1'b1, ircg_pkg::CARRIER_HIGH_IDX, h);
            apb(1'b1, ircg_pkg::CARRIER_LOW_IDX, l);
            apb(1'b1, ircg_pkg::MODE_IDX, {2'b01, c[1:0], 4'h0});
            run_len(1'b0, n);
            run_len(1'b1, n);
            run_len(1'b0, lo);
            run_len(1'b1, hi);
            cmp_val(hi, h * (c + 1));
            cmp_val(lo, l * (c + 1));
            apb(1'b1, ircg_pkg::MODE_IDX, 8'h00);
        end
        cmp_val({31'h0, flashes > 16'h4}, 32'h1);
        $display("test carrier done");
        // match spacing for every pulse tick source; carrier 1+1 gives divide 2
        apb(1'b1, ircg_pkg::CARRIER_HIGH_IDX, 8'h01);
        apb(1'b1, ircg_pkg::CARRIER_LOW_IDX, 8'h01);
        apb(1'b1, ircg_pkg::OUT_DATA_IDX, 8'h00);
        apb(1'b1, ircg_pkg::OUT_BUF_IDX, 8'h01);
        apb(1'b1, ircg_pkg::LEN_BUF_HIGH_IDX, 8'h00);
        apb(1'b1, ircg_pkg::LEN_HIGH_IDX, 8'h00);
        for (int s = 0; s < 8; s++) begin
            m = 8'(3 + $urandom % 4);
            apb(1'b1, ircg_pkg::LEN_LOW_IDX, 8'h01);
            apb(1'b1, ircg_pkg::LEN_BUF_LOW_IDX, m);
            apb(1'b1, ircg_pkg::MODE_IDX, {1'b0, s == 7, 2'b00, 1'b1, s[2:0]});
            run_flag(n);
            run_flag(n);
            cmp_val(n, m * divs[s]);
            apb(1'b1, ircg_pkg::MODE_IDX, 8'h00);
        end
        rd(ircg_pkg::OUT_DATA_IDX, 8'h01, 1'b0);
        apb(1'b1, ircg_pkg::MODE_IDX, 8'h88);
        rd(ircg_pkg::MODE_IDX, 8'h88, 1'b0);
        apb(1'b1, ircg_pkg::MODE_IDX, 8'h00);
        rd(ircg_pkg::MODE_IDX, 8'h00, 1'b0);
        $display("test pulse done");
        wrap_up();
    end
endmodule
`default_nettype wire
